/* synth_port_regs.vh */
// Constants of the three-wire synthesizer load port
`ifndef SYNTH_PORT_REGS_VH
`define SYNTH_PORT_REGS_VH

// ---------------------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------------------
`define WORD_BITS          24
`define SEL_HIGH_BIT       1
`define SEL_LOW_BIT        0

// ---------------------------------------------------------------------------
// Latch select codes
// ---------------------------------------------------------------------------
`define SEL_CONTROL        2'h0
`define SEL_REF_DIV        2'h1
`define SEL_FB_DIV         2'h2
`define SEL_TEST           2'h3

// ---------------------------------------------------------------------------
// Status output selections
// ---------------------------------------------------------------------------
`define MUX_LOCK           2'h0
`define MUX_FB_DIV         2'h1
`define MUX_REF_DIV        2'h2
`define MUX_LOW            2'h3

// ---------------------------------------------------------------------------
// Lock detect timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_PS      4000
`define LOCK_SET_ERR_PS    15000
`define LOCK_CLR_ERR_PS    25000
// Error widths in system clocks: set bound rounded down, clear bound rounded up
`define LOCK_SET_CYC       8'h03
`define LOCK_CLR_CYC       8'h07
`define LOCK_CNT_NORMAL    3'h3
`define LOCK_CNT_PRECISE   3'h5

`endif

/* lock_detect.v */
// Digital lock detector driven by phase error pulse widths
`timescale 1ns/1ps
`include "synth_port_regs.vh"

module lock_detect (
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  input  wire       enable_in,
  input  wire       lock_precision_bit_in,
  input  wire       err_active_in,
  input  wire       pd_cycle_in,
  output reg        locked_out
);

  reg [7:0] err_len_reg;
  reg [7:0] err_max_reg;
  reg [2:0] good_cnt_reg;
  wire [2:0] need_cnt;
  wire [7:0] err_eff;

  assign need_cnt = lock_precision_bit_in ? `LOCK_CNT_PRECISE : `LOCK_CNT_NORMAL;
  assign err_eff  = (err_len_reg > err_max_reg) ? err_len_reg : err_max_reg;

  // ---------------------------------------------------------------------------
  // Measure widest error pulse per cycle and judge it at cycle boundary
  // ---------------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (!rstn_in || !enable_in) begin
      err_len_reg  <= 8'h00;
      err_max_reg  <= 8'h00;
      good_cnt_reg <= 3'h0;
      locked_out   <= 1'b0;
    end else if (pd_cycle_in) begin
      err_len_reg <= 8'h00;
      err_max_reg <= 8'h00;
      if (err_eff < `LOCK_SET_CYC) begin
        if (good_cnt_reg + 3'h1 >= need_cnt)
          locked_out <= 1'b1; // RULE9
        else
          good_cnt_reg <= good_cnt_reg + 3'h1;
      end else begin
        good_cnt_reg <= 3'h0;
        if (err_eff > `LOCK_CLR_CYC)
          locked_out <= 1'b0; // RULE9
      end
    end else if (err_active_in) begin
      if (err_len_reg != 8'hFF)
        err_len_reg <= err_len_reg + 8'h01;
    end else begin
      err_max_reg <= err_eff;
      err_len_reg <= 8'h00;
    end
  end

endmodule // lock_detect

/* synth_three_wire_load_port.v */
// Three-wire load port with latches, power control and status output
`timescale 1ns/1ps
`include "synth_port_regs.vh"

// Operation
// RULE1 - Each serial clock rising edge shifts the data bit into 24-bit register.
// RULE2 - Words arrive most significant bit first; last two bits pick the latch.
// RULE3 - Load strobe rising copies the shift register into one selected latch.
// RULE4 - Select 00 control, 01 reference divider, 10 feedback divider, 11 test.
// RULE5 - Host must not load the factory test latch.
// RULE6 - Chip enable low powers down and floats the charge pump output.
// RULE7 - Chip enable high powers up only as software power-down bits allow.
// RULE8 - Status output shows lock detect, divided feedback or divided reference.
// RULE9 - Lock after 3 (or 5 precise) cycles under 15 ns; clears above 25 ns.
module synth_three_wire_load_port (
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire        serial_clk_in,
  input  wire        serial_data_in,
  input  wire        load_strobe_in,
  input  wire        chip_enable_in,
  input  wire        sw_power_down_in,
  input  wire [1:0]  status_select_in,
  input  wire        lock_precision_bit_in,
  input  wire        phase_err_in,
  input  wire        pd_cycle_in,
  input  wire        fb_div_in,
  input  wire        ref_div_in,
  output reg  [23:0] control_latch_out,
  output reg  [23:0] ref_div_latch_out,
  output reg  [23:0] fb_div_latch_out,
  output reg  [23:0] test_latch_out,
  output reg         powered_up_out,
  output reg         charge_pump_output_oe_out,
  output reg         status_mux_output_out
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers, three stages each
  // ---------------------------------------------------------------------------
  reg [2:0] sclk_sync_reg;
  reg [2:0] sdat_sync_reg;
  reg [2:0] load_sync_reg;
  reg [2:0] ce_sync_reg;
  reg [2:0] err_sync_reg;
  reg [2:0] fb_sync_reg;
  reg [2:0] ref_sync_reg;
  reg       sclk_state_reg;
  reg       sdat_state_reg;
  reg       load_state_reg;
  reg       ce_state_reg;
  reg       err_state_reg;
  reg       fb_state_reg;
  reg       ref_state_reg;
  reg [`WORD_BITS-1:0] shift_reg;
  wire      sclk_rise;
  wire      load_rise;
  wire      locked;
  // Next values and one-hot latch enables
  reg [`WORD_BITS-1:0] shift_next;
  reg [3:0] latch_hit;
  reg       power_next;
  reg       status_next;

  // Second and third agreeing stages confirm a new level
  // A pin pulse narrower than two clocks is dropped as a glitch
  function agreed;
    input [2:0] s;
    input       prev;
    begin
      agreed = (s[1] == s[2]) ? s[2] : prev;
    end
  endfunction

  // Shift all synchronisers on every clock
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sclk_sync_reg <= 3'h0;
      sdat_sync_reg <= 3'h0;
      load_sync_reg <= 3'h0;
      ce_sync_reg   <= 3'h0;
      err_sync_reg  <= 3'h0;
      fb_sync_reg   <= 3'h0;
      ref_sync_reg  <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clk_in};
      sdat_sync_reg <= {sdat_sync_reg[1:0], serial_data_in};
      load_sync_reg <= {load_sync_reg[1:0], load_strobe_in};
      ce_sync_reg   <= {ce_sync_reg[1:0], chip_enable_in};
      err_sync_reg  <= {err_sync_reg[1:0], phase_err_in};
      fb_sync_reg   <= {fb_sync_reg[1:0], fb_div_in};
      ref_sync_reg  <= {ref_sync_reg[1:0], ref_div_in};
    end
  end

  // Settled pin levels
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sclk_state_reg <= 1'b0;
      sdat_state_reg <= 1'b0;
      load_state_reg <= 1'b0;
      ce_state_reg   <= 1'b0;
      err_state_reg  <= 1'b0;
      fb_state_reg   <= 1'b0;
      ref_state_reg  <= 1'b0;
    end else begin
      sclk_state_reg <= agreed(sclk_sync_reg, sclk_state_reg);
      sdat_state_reg <= agreed(sdat_sync_reg, sdat_state_reg);
      load_state_reg <= agreed(load_sync_reg, load_state_reg);
      ce_state_reg   <= agreed(ce_sync_reg, ce_state_reg);
      err_state_reg  <= agreed(err_sync_reg, err_state_reg);
      fb_state_reg   <= agreed(fb_sync_reg, fb_state_reg);
      ref_state_reg  <= agreed(ref_sync_reg, ref_state_reg);
    end
  end

  // Rising edges of the settled serial clock and load strobe
  assign sclk_rise = agreed(sclk_sync_reg, sclk_state_reg) & ~sclk_state_reg;
  assign load_rise = agreed(load_sync_reg, load_state_reg) & ~load_state_reg;

  // ---------------------------------------------------------------------------
  // Shift register and latch load
  // ---------------------------------------------------------------------------
  // Data taken MSB first, so each new bit enters at the bottom
  always @* begin
    shift_next = shift_reg;
    if (sclk_rise)
      shift_next = {shift_reg[`WORD_BITS-2:0], sdat_state_reg}; // RULE1 RULE2
  end

  // Shift register, cleared only by reset; a stray edge just shifts once more
  always @(posedge sys_clk_in) begin
    if (!rstn_in)
      shift_reg <= 24'h000000;
    else
      shift_reg <= shift_next;
  end

  // Two trailing bits choose exactly one destination latch
  always @* begin
    latch_hit = 4'h0;
    if (load_rise) begin // RULE3
      case (shift_reg[`SEL_HIGH_BIT:`SEL_LOW_BIT]) // RULE2 RULE4
        `SEL_CONTROL: latch_hit = 4'h1;
        `SEL_REF_DIV: latch_hit = 4'h2;
        `SEL_FB_DIV:  latch_hit = 4'h4;
        default:      latch_hit = 4'h8; // RULE4
      endcase
    end
  end

  // Latches hold until the next load that selects them
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      control_latch_out <= 24'h000000;
      ref_div_latch_out <= 24'h000000;
      fb_div_latch_out  <= 24'h000000;
      test_latch_out    <= 24'h000000;
    end else begin
      if (latch_hit[0])
        control_latch_out <= shift_reg; // RULE3
      if (latch_hit[1])
        ref_div_latch_out <= shift_reg;
      if (latch_hit[2])
        fb_div_latch_out  <= shift_reg;
      if (latch_hit[3])
        test_latch_out    <= shift_reg; // Factory test latch, only when selected
    end
  end

  // ---------------------------------------------------------------------------
  // Power control and status output
  // ---------------------------------------------------------------------------
  // Hardware enable gates software power-down; either one holds the part down
  always @* begin
    power_next = ce_state_reg & ~sw_power_down_in; // RULE6 RULE7
  end

  // Charge pump floats whenever the part is down, so the loop filter keeps its charge
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      powered_up_out            <= 1'b0;
      charge_pump_output_oe_out <= 1'b0;
    end else begin
      powered_up_out            <= power_next; // RULE7
      charge_pump_output_oe_out <= power_next; // RULE6
    end
  end

  // Selected status source; the spare select parks the pin low
  always @* begin
    case (status_select_in) // RULE8
      `MUX_LOCK:    status_next = locked;
      `MUX_FB_DIV:  status_next = fb_state_reg;
      `MUX_REF_DIV: status_next = ref_state_reg;
      default:      status_next = 1'b0;
    endcase
  end

  // Status pin register
  always @(posedge sys_clk_in) begin
    if (!rstn_in)
      status_mux_output_out <= 1'b0;
    else
      status_mux_output_out <= status_next; // RULE8
  end

  // ---------------------------------------------------------------------------
  // Lock detect
  // ---------------------------------------------------------------------------
  // Held clear while the part is powered down, so lock restarts from scratch
  lock_detect u_lock_detect (
    .sys_clk_in            (sys_clk_in),
    .rstn_in               (rstn_in),
    .enable_in             (powered_up_out),
    .lock_precision_bit_in (lock_precision_bit_in),
    .err_active_in         (err_state_reg),
    .pd_cycle_in           (pd_cycle_in),
    .locked_out            (locked)
  );

endmodule // synth_three_wire_load_port

/* port_chk_sva.sv */
// Assertion checker for the three-wire load port
`timescale 1ns/1ps
module port_chk (
  input wire        sys_clk_in,
  input wire        rstn_in,
  input wire        load_strobe_in,
  input wire        chip_enable_in,
  input wire        sw_power_down_in,
  input wire [1:0]  status_select_in,
  input wire        fb_div_in,
  input wire        ref_div_in,
  input wire [23:0] control_latch_out,
  input wire [23:0] ref_div_latch_out,
  input wire [23:0] fb_div_latch_out,
  input wire [23:0] test_latch_out,
  input wire        powered_up_out,
  input wire        charge_pump_output_oe_out,
  input wire        status_mux_output_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire [95:0] lat = {control_latch_out, ref_div_latch_out, fb_div_latch_out, test_latch_out};
  // Pins held still long enough to pass the synchronisers
  sequence s_ce_low; !chip_enable_in [*8]; endsequence
  sequence s_no_load; !load_strobe_in [*8]; endsequence
  a_cp_float: assert property (s_ce_low |=> !charge_pump_output_oe_out)
    else $error("charge pump not floating");
  a_ce_down: assert property (s_ce_low |-> !powered_up_out)
    else $error("powered while disabled");
  a_sw_down: assert property (sw_power_down_in [*4] |-> !powered_up_out)
    else $error("powered against software bit");
  a_power_on: assert property ((chip_enable_in && !sw_power_down_in) [*8] |=> powered_up_out)
    else $error("not powered up");
  a_mux_low: assert property ((status_select_in == 2'h3) [*3] |-> !status_mux_output_out)
    else $error("idle status not low");
  a_mux_fb: assert property ((status_select_in == 2'h1 && fb_div_in) [*6] |-> status_mux_output_out)
    else $error("feedback not routed");
  a_mux_ref: assert property ((status_select_in == 2'h2 && ref_div_in) [*6] |-> status_mux_output_out)
    else $error("reference not routed");
  a_lock_off: assert property ((status_select_in == 2'h0 && !powered_up_out) [*4] |-> !status_mux_output_out)
    else $error("lock shown while down");
  a_latch_hold: assert property (s_no_load |-> $stable(lat))
    else $error("latch moved without load");
  a_one_latch: assert property ($countones({$changed(control_latch_out), $changed(ref_div_latch_out),
    $changed(fb_div_latch_out), $changed(test_latch_out)}) <= 1)
    else $error("several latches loaded");
endmodule // port_chk
bind synth_three_wire_load_port port_chk u_chk (
  .sys_clk_in                (sys_clk_in),
  .rstn_in                   (rstn_in),
  .load_strobe_in            (load_strobe_in),
  .chip_enable_in            (chip_enable_in),
  .sw_power_down_in          (sw_power_down_in),
  .status_select_in          (status_select_in),
  .fb_div_in                 (fb_div_in),
  .ref_div_in                (ref_div_in),
  .control_latch_out         (control_latch_out),
  .ref_div_latch_out         (ref_div_latch_out),
  .fb_div_latch_out          (fb_div_latch_out),
  .test_latch_out            (test_latch_out),
  .powered_up_out            (powered_up_out),
  .charge_pump_output_oe_out (charge_pump_output_oe_out),
  .status_mux_output_out     (status_mux_output_out)
);

/* host_model.sv */
// Host-side driver of the three-wire programming pins
`timescale 1ns/1ps
module host_model (
  output reg serial_clk_out,
  output reg serial_data_out,
  output reg load_strobe_out
);
  integer i;
  // Link clock rests low between frames
  initial begin
    serial_clk_out = 1'h0;
    serial_data_out = 1'h0;
    load_strobe_out = 1'h0;
  end
  // Shifts a word out top bit first, then pulses the strobe
  task send_word(input [23:0] word);
    begin
      for (i = 23; i >= 0; i = i - 1) begin
        serial_data_out = word[i];
        #40 serial_clk_out = 1'h1;
        #40 serial_clk_out = 1'h0;
      end
      serial_data_out = ~word[0];
      #20 load_strobe_out = 1'h1;
      #40 load_strobe_out = 1'h0;
      #40;
    end
  endtask
endmodule // host_model

/* tb.sv */
// Self-checking bench for the three-wire load port
`timescale 1ns/1ps
module tb;
  reg         sys_clk_in, rstn_in, chip_enable_in, sw_power_down_in;
  reg  [1:0]  status_select_in;
  reg         lock_precision_bit_in, phase_err_in, pd_cycle_in, fb_div_in, ref_div_in;
  wire        sclk, sdat, strobe, powered_up, cp_oe, status_out;
  wire [23:0] lat [0:3];
  reg  [23:0] exp_lat [0:3];
  integer     miscompares, compares, cycles, s, k;

  host_model u_host (.serial_clk_out(sclk), .serial_data_out(sdat), .load_strobe_out(strobe));
  synth_three_wire_load_port u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .serial_clk_in(sclk), .serial_data_in(sdat), .load_strobe_in(strobe),
    .chip_enable_in(chip_enable_in), .sw_power_down_in(sw_power_down_in),
    .status_select_in(status_select_in), .lock_precision_bit_in(lock_precision_bit_in),
    .phase_err_in(phase_err_in), .pd_cycle_in(pd_cycle_in), .fb_div_in(fb_div_in),
    .ref_div_in(ref_div_in), .control_latch_out(lat[0]), .ref_div_latch_out(lat[1]),
    .fb_div_latch_out(lat[2]), .test_latch_out(lat[3]), .powered_up_out(powered_up),
    .charge_pump_output_oe_out(cp_oe), .status_mux_output_out(status_out));

  // ------------------------------
  // Clock, timeout and helpers
  // ------------------------------
  initial begin
    sys_clk_in = 1'h0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task check(input [23:0] got, input [23:0] want);
    begin
      compares = compares + 1;
      if (got !== want) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk_in);
      #1;
    end
  endtask
  // Routes one source to the status pin and checks the level
  task mux_case(input [1:0] sel, input f, input r, input want);
    begin
      status_select_in = sel;
      fb_div_in = f;
      ref_div_in = r;
      tick(10);
      check({23'h0, status_out}, {23'h0, want});
    end
  endtask
  // One detector cycle whose error pulse is n clocks wide
  task pd(input integer n);
    begin
      phase_err_in = 1'h1;
      tick(n);
      phase_err_in = 1'h0;
      tick(4);
      pd_cycle_in = 1'h1;
      tick(1);
      pd_cycle_in = 1'h0;
      tick(4);
    end
  endtask
  task final_report;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  initial begin
    {rstn_in, sw_power_down_in, status_select_in, lock_precision_bit_in} = 5'h0;
    {phase_err_in, pd_cycle_in, fb_div_in, ref_div_in} = 4'h0;
    chip_enable_in = 1'h1;
    {miscompares, compares, cycles} = 96'h0;
    for (k = 0; k < 4; k = k + 1) exp_lat[k] = 24'h0;
    tick(16);
    rstn_in = 1'h1;
    tick(8);
    // Every select code, the factory one once on purpose, lands in one latch
    for (s = 0; s < 4; s = s + 1) begin
      exp_lat[s] = {s[1:0], 20'h3A5F0, s[1:0]};
      u_host.send_word(exp_lat[s]);
      tick(12);
      for (k = 0; k < 4; k = k + 1) check(lat[k], exp_lat[k]);
    end
    $display("Latch decode test done");
    chip_enable_in = 1'h0;
    tick(10);
    check({22'h0, powered_up, cp_oe}, 24'h0);
    chip_enable_in = 1'h1;
    sw_power_down_in = 1'h1;
    tick(10);
    check({22'h0, powered_up, cp_oe}, 24'h0);
    sw_power_down_in = 1'h0;
    tick(10);
    check({22'h0, powered_up, cp_oe}, 24'h3);
    $display("Power test done");
    mux_case(2'h1, 1'h1, 1'h0, 1'h1);
    mux_case(2'h1, 1'h0, 1'h1, 1'h0);
    mux_case(2'h2, 1'h0, 1'h1, 1'h1);
    mux_case(2'h2, 1'h1, 1'h0, 1'h0);
    mux_case(2'h3, 1'h1, 1'h1, 1'h0);
    $display("Status select test done");
    mux_case(2'h0, 1'h0, 1'h0, 1'h0);
    pd(1);
    pd(1);
    check({23'h0, status_out}, 24'h0);
    pd(1);
    check({23'h0, status_out}, 24'h1);
    pd(9);
    check({23'h0, status_out}, 24'h0);
    lock_precision_bit_in = 1'h1;
    repeat (4) pd(1);
    check({23'h0, status_out}, 24'h0);
    pd(1);
    check({23'h0, status_out}, 24'h1);
    // Powering down while locked must clear the shown lock
    chip_enable_in = 1'h0;
    tick(10);
    check({23'h0, status_out}, 24'h0);
    $display("Lock detect test done");
    final_report;
  end
endmodule // tb
